// ===== hdl/dprb_ram.sv
// dprb_ram: dual-port memory with four clocking modes and read-side error status
// assumes: primary and secondary clocks arrive as inputs synchronous to ref_clk_i,
// each held for at least one ref_clk_i cycle high and low; user logic keeps its own widths
`timescale 1ns/1ps
`default_nettype none

module dprb_ram #(
  parameter dprb_pkg::dprb_clk_mode_e CLK_MODE = dprb_pkg::DPRB_CLK_SINGLE,
  parameter dprb_pkg::dprb_op_mode_e OP_MODE = dprb_pkg::DPRB_OP_SIMPLE_TWO_PORT,
  parameter int DATA_W = dprb_pkg::DPRB_DATA_W_DEF,
  parameter int ADDR_W = dprb_pkg::DPRB_ADDR_W_DEF,
  parameter int ECCST_W = dprb_pkg::DPRB_ECCST_W_DEF,
  parameter bit ECC_EN = 1'b0,
  parameter bit ACLR_ADDR_A = 1'b1,
  parameter bit ACLR_Q_A = 1'b1,
  parameter bit ACLR_ADDR_B = 1'b1,
  parameter bit ACLR_Q_B = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic primary_clk_i,
  input wire logic secondary_clk_i,
  input wire logic primary_clk_gate_first_i,
  input wire logic secondary_clk_gate_i,
  input wire logic primary_async_clear_i,
  input wire logic secondary_async_clear_i,
  input wire logic [ADDR_W-1:0] addr_a_i,
  input wire logic [DATA_W-1:0] wr_data_a_i,
  input wire logic wr_en_a_i,
  input wire logic [ADDR_W-1:0] addr_b_i,
  input wire logic addr_b_hold_i,
  input wire logic [DATA_W-1:0] wr_data_b_i,
  input wire logic wr_en_b_i,
  input wire logic [1:0] err_inject_i,
  output logic [DATA_W-1:0] q_a_o,
  output logic [DATA_W-1:0] q_b_o,
  output logic [ECCST_W-1:0] ecc_status_o
);

  // ----------------------------------------------------------------
  // derived sizes
  // ----------------------------------------------------------------
  localparam int DEPTH = 2 ** ADDR_W;
  localparam int HAM_W = $clog2(DATA_W) + 1;
  localparam int CHK_W = HAM_W + 1;
  localparam int POS_MAX = 2 ** HAM_W;
  localparam bit TRUE_MODE = (OP_MODE == dprb_pkg::DPRB_OP_TRUE_TWO_PORT);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (DATA_W < 4 || ADDR_W < 1 || ADDR_W > 16) begin : g_bad_size
      $error("dprb_ram: data width below 4 or address width out of range");
    end
    if (DATA_W + CHK_W > POS_MAX) begin : g_bad_code
      $error("dprb_ram: check code too narrow for data width");
    end
    if (ECCST_W != 2 && ECCST_W != 3) begin : g_bad_stat
      $error("dprb_ram: status width must be 2 or 3");
    end
    if (ECC_EN && TRUE_MODE) begin : g_bad_ecc
      $error("dprb_ram: error status only in simple two-port mode");
    end
  endgenerate

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // domain of a register group: 1 means secondary clock
  function automatic logic on_secondary(input dprb_pkg::dprb_clk_mode_e mode,
                                        input dprb_pkg::dprb_group_e grp);
    logic sec;
    sec = 1'b0;
    case (mode)
      dprb_pkg::DPRB_CLK_SINGLE: begin
        sec = 1'b0;
      end
      // write side primary, read side secondary
      dprb_pkg::DPRB_CLK_READ_WRITE: begin
        sec = (grp == dprb_pkg::DPRB_GRP_B_IN) || (grp == dprb_pkg::DPRB_GRP_B_OUT);
      end
      dprb_pkg::DPRB_CLK_INPUT_OUTPUT: begin
        sec = (grp == dprb_pkg::DPRB_GRP_A_OUT) || (grp == dprb_pkg::DPRB_GRP_B_OUT);
      end
      // port A primary, port B secondary
      dprb_pkg::DPRB_CLK_INDEPENDENT: begin
        sec = (grp == dprb_pkg::DPRB_GRP_B_IN) || (grp == dprb_pkg::DPRB_GRP_B_OUT);
      end
      default: begin
        sec = 1'b0;
      end
    endcase
    return sec;
  endfunction

  // hamming syndrome of a data word, data bits at non power of two positions
  function automatic logic [HAM_W-1:0] ham_of(input logic [DATA_W-1:0] d);
    logic [HAM_W-1:0] s;
    int k;
    s = '0;
    k = 0;
    for (int p = 1; p < POS_MAX; p++) begin
      if (((p & (p - 1)) != 0) && (k < DATA_W)) begin
        if (d[k]) begin
          s = s ^ HAM_W'(p);
        end
        k++;
      end
    end
    return s;
  endfunction

  // data bit mask for a syndrome that points at a data position
  function automatic logic [DATA_W-1:0] fix_of(input logic [HAM_W-1:0] syn);
    logic [DATA_W-1:0] m;
    int k;
    m = '0;
    k = 0;
    for (int p = 1; p < POS_MAX; p++) begin
      if (((p & (p - 1)) != 0) && (k < DATA_W)) begin
        if (HAM_W'(p) == syn) begin
          m[k] = 1'b1;
        end
        k++;
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // clock edge detection and gating
  // ----------------------------------------------------------------
  logic prim_prev;
  logic sec_prev;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prim_prev <= dprb_pkg::DPRB_RST_EDGE;
      sec_prev <= dprb_pkg::DPRB_RST_EDGE;
    end else begin
      prim_prev <= primary_clk_i;
      sec_prev <= secondary_clk_i;
    end
  end

  wire logic prim_rise = primary_clk_i & ~prim_prev;
  wire logic sec_rise = secondary_clk_i & ~sec_prev;
  wire logic prim_tick = prim_rise & primary_clk_gate_first_i;
  wire logic sec_tick = sec_rise & secondary_clk_gate_i;

  localparam bit SEC_A_IN = on_secondary(CLK_MODE, dprb_pkg::DPRB_GRP_A_IN);
  localparam bit SEC_A_OUT = on_secondary(CLK_MODE, dprb_pkg::DPRB_GRP_A_OUT);
  localparam bit SEC_B_IN = on_secondary(CLK_MODE, dprb_pkg::DPRB_GRP_B_IN);
  localparam bit SEC_B_OUT = on_secondary(CLK_MODE, dprb_pkg::DPRB_GRP_B_OUT);

  wire logic tick_a_in = SEC_A_IN ? sec_tick : prim_tick;
  wire logic tick_a_out = SEC_A_OUT ? sec_tick : prim_tick;
  wire logic tick_b_in = SEC_B_IN ? sec_tick : prim_tick;
  wire logic tick_b_out = SEC_B_OUT ? sec_tick : prim_tick;

  // ----------------------------------------------------------------
  // asynchronous clears per register group
  // ----------------------------------------------------------------
  // clear follows the group's domain
  wire logic clr_a_in = SEC_A_IN ? secondary_async_clear_i : primary_async_clear_i;
  wire logic clr_a_out = SEC_A_OUT ? secondary_async_clear_i : primary_async_clear_i;
  wire logic clr_b_in = SEC_B_IN ? secondary_async_clear_i : primary_async_clear_i;
  wire logic clr_b_out = SEC_B_OUT ? secondary_async_clear_i : primary_async_clear_i;

  wire logic rst_addr_a_n = rst_n_i & ~(ACLR_ADDR_A & clr_a_in);
  wire logic rst_q_a_n = rst_n_i & ~(ACLR_Q_A & clr_a_out);
  wire logic rst_addr_b_n = rst_n_i & ~(ACLR_ADDR_B & clr_b_in);
  wire logic rst_q_b_n = rst_n_i & ~(ACLR_Q_B & clr_b_out);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [CHK_W-1:0] chk [DEPTH];

  // stored code is computed before injection so injected flips read back as errors
  wire logic [HAM_W-1:0] wr_ham_a = ham_of(wr_data_a_i);
  wire logic wr_par_a = (^wr_data_a_i) ^ (^wr_ham_a);
  wire logic [CHK_W-1:0] wr_chk_a = {wr_par_a, wr_ham_a};
  wire logic [DATA_W-1:0] inj_mask = {{(DATA_W-2){1'b0}}, err_inject_i};
  wire logic [DATA_W-1:0] wr_word_a = ECC_EN ? (wr_data_a_i ^ inj_mask) : wr_data_a_i;
  wire logic wr_a = tick_a_in & wr_en_a_i;
  wire logic wr_b = TRUE_MODE & tick_b_in & wr_en_b_i;

  // port A wins when both write one address
  always_ff @(posedge ref_clk_i) begin
    if (wr_b) begin
      mem[addr_b_i] <= wr_data_b_i;
    end
    if (wr_a) begin
      mem[addr_a_i] <= wr_word_a;
      chk[addr_a_i] <= wr_chk_a;
    end
  end

  // ----------------------------------------------------------------
  // port A address and read output
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_a_q;

  always_ff @(posedge ref_clk_i or negedge rst_addr_a_n) begin
    if (!rst_addr_a_n) begin
      addr_a_q <= '0;
    end else if (tick_a_in) begin
      addr_a_q <= addr_a_i;
    end
  end

  wire logic [DATA_W-1:0] rd_word_a = TRUE_MODE ? mem[addr_a_q] : '0;

  always_ff @(posedge ref_clk_i or negedge rst_q_a_n) begin
    if (!rst_q_a_n) begin
      q_a_o <= '0;
    end else if (tick_a_out) begin
      q_a_o <= rd_word_a;
    end
  end

  // ----------------------------------------------------------------
  // port B address with hold
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_b_q;
  wire logic load_addr_b = tick_b_in & ~addr_b_hold_i;

  always_ff @(posedge ref_clk_i or negedge rst_addr_b_n) begin
    if (!rst_addr_b_n) begin
      addr_b_q <= '0;
    end else if (load_addr_b) begin
      addr_b_q <= addr_b_i;
    end
  end

  // ----------------------------------------------------------------
  // port B read path and error decode
  // ----------------------------------------------------------------
  wire logic [DATA_W-1:0] rd_raw_b = mem[addr_b_q];
  wire logic [CHK_W-1:0] rd_chk_b = chk[addr_b_q];
  wire logic [HAM_W-1:0] rd_syn = rd_chk_b[HAM_W-1:0] ^ ham_of(rd_raw_b);
  wire logic rd_odd = (^rd_raw_b) ^ (^rd_chk_b);
  wire logic err_single = rd_odd;
  wire logic err_fatal = ~rd_odd & (rd_syn != '0);
  wire logic [DATA_W-1:0] rd_fixed = rd_raw_b ^ (err_single ? fix_of(rd_syn) : '0);

  wire logic [2:0] stat_code = err_fatal ? dprb_pkg::DPRB_ECC_FATAL :
                               err_single ? dprb_pkg::DPRB_ECC_CORRECTED :
                               dprb_pkg::DPRB_ECC_NONE;
  wire logic [2:0] stat_eff = ECC_EN ? stat_code : dprb_pkg::DPRB_ECC_NONE;
  wire logic [ECCST_W-1:0] next_ecc_status = stat_eff[ECCST_W-1:0];
  // read word has the write width
  wire logic [DATA_W-1:0] next_q_b = ECC_EN ? rd_fixed : rd_raw_b;

  always_ff @(posedge ref_clk_i or negedge rst_q_b_n) begin
    if (!rst_q_b_n) begin
      q_b_o <= '0;
      ecc_status_o <= '0;
    end else if (tick_b_out) begin
      q_b_o <= next_q_b;
      ecc_status_o <= next_ecc_status;
    end
  end

  // both address ports share ADDR_W by construction

endmodule // dprb_ram

`default_nettype wire

// ===== hdl/dprb_pkg.sv
// dprb_pkg: constants and types shared by the dual-port memory block
// assumes: imported by scope only, never by an import statement
package dprb_pkg;

  // ----------------------------------------------------------------
  // clocking and operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPRB_CLK_SINGLE       = 2'h0,
    DPRB_CLK_READ_WRITE   = 2'h1,
    DPRB_CLK_INPUT_OUTPUT = 2'h3,
    DPRB_CLK_INDEPENDENT  = 2'h2
  } dprb_clk_mode_e;

  typedef enum logic {
    DPRB_OP_SIMPLE_TWO_PORT = 1'h0,
    DPRB_OP_TRUE_TWO_PORT   = 1'h1
  } dprb_op_mode_e;

  // register groups that each pick a clock domain
  typedef enum logic [1:0] {
    DPRB_GRP_A_IN  = 2'h0,
    DPRB_GRP_A_OUT = 2'h1,
    DPRB_GRP_B_IN  = 2'h3,
    DPRB_GRP_B_OUT = 2'h2
  } dprb_group_e;

  // ----------------------------------------------------------------
  // error status codes, all zeros is no error
  // ----------------------------------------------------------------
  localparam logic [2:0] DPRB_ECC_NONE      = 3'h0;
  localparam logic [2:0] DPRB_ECC_CORRECTED = 3'h1;
  localparam logic [2:0] DPRB_ECC_FATAL     = 3'h2;

  // ----------------------------------------------------------------
  // defaults and values after reset
  // ----------------------------------------------------------------
  localparam int DPRB_DATA_W_DEF = 16;
  localparam int DPRB_ADDR_W_DEF = 8;
  localparam int DPRB_ECCST_W_DEF = 3;
  localparam logic DPRB_RST_EDGE = 1'h0;
  localparam logic [1:0] DPRB_INJ_NONE = 2'h0;

endpackage

// ===== dv/dprb_ram_properties.sv
// checker: port properties of dprb_ram
// assumes: single clock mode, simple two-port, one instance
`timescale 1ns/1ps
`default_nettype none
module dprb_ram_properties #(
  parameter int DATA_W = 16,
  parameter int ECCST_W = 3
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic primary_clk_i,
  input wire logic primary_clk_gate_first_i,
  input wire logic primary_async_clear_i,
  input wire logic secondary_async_clear_i,
  input wire logic [DATA_W-1:0] q_a_o,
  input wire logic [DATA_W-1:0] q_b_o,
  input wire logic [ECCST_W-1:0] ecc_status_o
);
  logic prim_d;
  wire logic tick;
  assign tick = primary_clk_i & ~prim_d & primary_clk_gate_first_i;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) prim_d <= 1'h0;
    else prim_d <= primary_clk_i;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_q_b_hold: assert property (!tick ##1 !primary_async_clear_i |-> $stable(q_b_o))
    else $error("q_b moved without a tick");
  a_status_hold: assert property (!tick ##1 !primary_async_clear_i |-> $stable(ecc_status_o))
    else $error("status moved without a tick");
  a_gate_off: assert property (!primary_clk_gate_first_i ##1 !primary_async_clear_i |->
    $stable(q_b_o) && $stable(ecc_status_o))
    else $error("gated tick changed outputs");
  a_sec_ignored: assert property (secondary_async_clear_i && !tick ##1 !primary_async_clear_i
    |-> $stable(q_b_o))
    else $error("secondary clear acted in single mode");
  a_clear_now: assert property (primary_async_clear_i |-> q_b_o == '0 && ecc_status_o == '0)
    else $error("clear not immediate");
  a_clear_after: assert property (primary_async_clear_i ##1 !primary_async_clear_i |-> q_b_o == '0)
    else $error("q_b not cleared");
  a_q_a_idle: assert property (q_a_o == '0)
    else $error("q_a active in simple mode");
  a_status_code: assert property (ecc_status_o <= 2)
    else $error("undefined status code");
endmodule // dprb_ram_properties
bind dprb_ram dprb_ram_properties #(.DATA_W(DATA_W), .ECCST_W(ECCST_W)) u_props (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .primary_clk_i(primary_clk_i),
  .primary_clk_gate_first_i(primary_clk_gate_first_i),
  .primary_async_clear_i(primary_async_clear_i),
  .secondary_async_clear_i(secondary_async_clear_i),
  .q_a_o(q_a_o),
  .q_b_o(q_b_o),
  .ecc_status_o(ecc_status_o)
);
`default_nettype wire

// ===== dv/dprb_user_clk.sv
// partner: fabric logic making the memory clocks
// assumes: ref_clk_i from the bench; clocks stand still while run_i is low
`timescale 1ns/1ps
`default_nettype none
module dprb_user_clk (
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic slow_i,
  output logic primary_clk_o,
  output logic secondary_clk_o
);
  logic ph;
  logic [1:0] sc;
  initial begin
    ph = 1'h0;
    sc = 2'h0;
    primary_clk_o = 1'h0;
    secondary_clk_o = 1'h0;
  end
  always @(posedge ref_clk_i) begin
    ph <= ~ph;
    sc <= (sc == 2'h2) ? 2'h0 : sc + 2'h1;
    if (run_i && (!slow_i || ph)) primary_clk_o <= ~primary_clk_o;
    if (run_i && sc == 2'h0) secondary_clk_o <= ~secondary_clk_o;
  end
endmodule // dprb_user_clk
`default_nettype wire

// ===== dv/dprb_ram_tb_top.sv
// bench: random traffic on dprb_ram against a queue-free memory model
// assumes: single clock mode with error status on
`timescale 1ns/1ps
`default_nettype none
module dprb_ram_tb_top;
  localparam int DW = 16;
  localparam int AW = 8;
  logic ref_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic pclk, sclk, run = 1'h0, slow = 1'h0, pd = 1'h0;
  logic gate = 1'h0, sgate = 1'h0, pclr = 1'h0, sclr = 1'h0, we_a = 1'h0, hold = 1'h0;
  logic [AW-1:0] addr_a = '0, addr_b = '0;
  logic [DW-1:0] wd_a = '0, q_a, q_b;
  logic [1:0] inj = 2'h0;
  logic [2:0] st;
  logic [31:0] seed = 32'hee94_e6dc;
  int error_cnt = 0, compares = 0, cyc = 0, areg = 0, exp_q = 0, exp_st = 0;
  int mem [int];
  int sts [int];
  bit exp_ok = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  dprb_user_clk u_clk (.ref_clk_i(ref_clk_i), .run_i(run), .slow_i(slow),
    .primary_clk_o(pclk), .secondary_clk_o(sclk));
  dprb_ram #(.DATA_W(DW), .ADDR_W(AW), .ECC_EN(1'h1)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .primary_clk_i(pclk), .secondary_clk_i(sclk),
    .primary_clk_gate_first_i(gate), .secondary_clk_gate_i(sgate),
    .primary_async_clear_i(pclr), .secondary_async_clear_i(sclr),
    .addr_a_i(addr_a), .wr_data_a_i(wd_a), .wr_en_a_i(we_a), .addr_b_i(addr_b),
    .addr_b_hold_i(hold), .wr_data_b_i('0), .wr_en_b_i(1'h0), .err_inject_i(inj),
    .q_a_o(q_a), .q_b_o(q_b), .ecc_status_o(st));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_data(input logic [DW-1:0] e);
    compares++;
    if (q_b !== e) begin
      error_cnt++;
      $display("BAD %0t read data %h expected %h", $time, q_b, e);
    end
  endtask
  task automatic chk_stat(input logic [2:0] e);
    compares++;
    if (st !== e) begin
      error_cnt++;
      $display("BAD %0t status %h expected %h", $time, st, e);
    end
  endtask
  // ----
  // model: tick, read old word, write, capture address
  // ----
  always @(posedge ref_clk_i) begin
    pd <= pclk;
    if (!rst_n_i) begin
      areg <= 0;
      exp_ok <= 1;
      exp_q <= 0;
      exp_st <= 0;
    end else if (pclr) begin
      areg <= 0;
      exp_ok <= 1;
      exp_q <= 0;
      exp_st <= 0;
    end else if (pclk && !pd && gate) begin
      exp_ok <= mem.exists(areg);
      if (mem.exists(areg)) begin
        exp_q <= mem[areg];
        exp_st <= sts[areg];
      end
      if (!hold) areg <= int'(addr_b);
    end
    // memory is never cleared: writes go on under a clear, after the old word is read
    if (rst_n_i && pclk && !pd && gate && we_a) begin
      mem[int'(addr_a)] = int'(wd_a);
      sts[int'(addr_a)] = (inj == 2'h3) ? 2 : int'(inj != 2'h0);
    end
  end
  always @(negedge ref_clk_i) begin
    if (rst_n_i && (pclr || exp_ok)) begin
      if (pclr || exp_st != 2) chk_data(pclr ? '0 : exp_q[DW-1:0]);
      chk_stat(pclr ? 3'h0 : exp_st[2:0]);
    end
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ----
  // prefill: write every used address under a clear so no read sees an empty word
  // ----
  task automatic prefill();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_i);
      seed = xs(seed);
      addr_a <= AW'(i);
      wd_a <= seed[15:0];
      we_a <= 1'h1;
      gate <= 1'h1;
      pclr <= 1'h1;
      run <= 1'h1;
      @(posedge ref_clk_i);
    end
    $display("done prefill");
  endtask
  // ----
  // stimulus phases, thresholds out of 256
  // ----
  task automatic run_phase(input string nm, input int clr, input int goff, input int hd,
    input bit sl);
    logic c;
    repeat (1500) begin
      @(posedge ref_clk_i);
      seed = xs(seed);
      addr_a <= {4'h0, seed[3:0]};
      addr_b <= {4'h0, seed[7:4]};
      wd_a <= seed[23:8];
      inj <= seed[25:24];
      seed = xs(seed);
      c = int'(seed[15:8]) < clr;
      pclr <= c;
      we_a <= seed[0] && !c;
      hold <= int'(seed[23:16]) < hd;
      gate <= int'(seed[31:24]) >= goff;
      sclr <= seed[1];
      sgate <= seed[2];
      run <= 1'h1;
      slow <= sl;
    end
    $display("done %s", nm);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    prefill();
    run_phase("back to back", 0, 0, 0, 0);
    run_phase("hold and gate", 0, 96, 128, 1);
    run_phase("clears", 24, 32, 64, 1);
    run_phase("mixed", 8, 48, 96, 0);
    report_and_stop();
  end
endmodule // dprb_ram_tb_top
`default_nettype wire
